// >>> tsa_host.sv
`timescale 1ns/100ps
module tsa_host (
	input wire logic clk,
	input wire logic sda_i,
	output logic scl,
	output logic sda_oe
);
	// Bus phases in clk cycles, above the minimum low and high times
	localparam int LOW = 34;
	localparam int HIGH = 16;
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	// Start or repeated start
	task automatic start();
		sda_oe <= 1'b0;
		hold(17);
		scl <= 1'b1;
		hold(17);
		sda_oe <= 1'b1;
		hold(17);
		scl <= 1'b0;
		hold(17);
	endtask : start
	task automatic bit_io(input logic b, output logic r);
		sda_oe <= ~b;
		hold(LOW);
		scl <= 1'b1;
		hold(1);
		r = sda_i;
		hold(HIGH);
		scl <= 1'b0;
		hold(2);
	endtask : bit_io
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : put
	task automatic get(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask : get
	task automatic stop();
		sda_oe <= 1'b1;
		hold(LOW);
		scl <= 1'b1;
		hold(17);
		sda_oe <= 1'b0;
		hold(LOW);
	endtask : stop
endmodule : tsa_host

// >>> tsa_link.sv
`timescale 1ns/100ps
module tsa_link #(
	parameter logic [3:0] ADDR_BASE = tsa_pkg::ADDR_BASE
) (
	input wire logic link_clk,
	input wire logic resetn,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [2:0] addr_sel_i,
	input wire logic abort_tgl,
	input wire logic [15:0] rd_word,
	output logic sda_oe,
	output logic busy,
	output logic rd_req_tgl,
	output logic wr_tgl,
	output tsa_pkg::tsa_xfer_t xfer
);
	typedef enum {L_IDLE, L_ADDR, L_ACK_A, L_PTR, L_ACK_P, L_WDAT, L_ACK_W, L_RDAT,
		L_ACK_R, L_RNEXT} tsa_lstate_t;
	tsa_lstate_t state_ff;
	logic [1:0] rst_ff;
	logic rst_n;
	logic [2:0] scl_ff;
	logic [2:0] sda_ff;
	logic [2:0] abort_ff;
	logic [2:0] asel0_ff;
	logic [2:0] asel1_ff;
	logic [2:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [7:0] ptr_ff;
	logic [15:0] data_ff;
	logic [1:0] nbyt_ff;
	logic rw_ff;
	logic lo_ff;
	logic oe_ff;
	logic busy_ff;
	logic req_ff;
	logic wr_ff;
	logic scl_hi;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	logic abort;
	logic [7:0] byte_in;

	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) rst_ff <= 2'h0;
		else rst_ff <= {rst_ff[0], 1'b1};
	end
	assign rst_n = rst_ff[1];

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_ff <= 3'h7;
			sda_ff <= 3'h7;
			abort_ff <= 3'h0;
			asel0_ff <= 3'h0;
			asel1_ff <= 3'h0;
		end else begin
			scl_ff <= {scl_ff[1:0], scl_i};
			sda_ff <= {sda_ff[1:0], sda_i};
			abort_ff <= {abort_ff[1:0], abort_tgl};
			asel0_ff <= addr_sel_i;
			asel1_ff <= asel0_ff;
		end
	end

	assign scl_hi = scl_ff[1] & scl_ff[2];
	assign start = scl_hi & sda_ff[2] & ~sda_ff[1];
	assign stop = scl_hi & ~sda_ff[2] & sda_ff[1];
	assign rise = scl_ff[1] & ~scl_ff[2];
	assign fall = ~scl_ff[1] & scl_ff[2];
	assign abort = abort_ff[1] ^ abort_ff[2];
	assign byte_in = {sh_ff[6:0], sda_ff[1]};

	// ----------------------------------------
	// Bit engine
	// ----------------------------------------
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= L_IDLE;
			cnt_ff <= 3'h0;
			sh_ff <= 8'h00;
			ptr_ff <= tsa_pkg::PTR_RST;
			data_ff <= tsa_pkg::REG_RST;
			nbyt_ff <= 2'h0;
			rw_ff <= 1'b0;
			lo_ff <= 1'b0;
			oe_ff <= 1'b0;
			busy_ff <= 1'b0;
			req_ff <= 1'b0;
			wr_ff <= 1'b0;
		end else if (abort) begin
			state_ff <= L_IDLE;
			oe_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (start) begin
			state_ff <= L_ADDR;
			cnt_ff <= 3'h0;
			oe_ff <= 1'b0;
			busy_ff <= 1'b1;
			nbyt_ff <= 2'h0;
		end else if (stop) begin
			if (busy_ff && !rw_ff && nbyt_ff == 2'h2) wr_ff <= ~wr_ff;
			state_ff <= L_IDLE;
			oe_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (rise) begin
			unique case (state_ff)
				L_ADDR, L_PTR, L_WDAT: begin
					sh_ff <= byte_in;
					cnt_ff <= cnt_ff + 3'h1;
					if (cnt_ff == 3'h7) begin
						if (state_ff == L_ADDR) begin
							if (byte_in[7:1] == {ADDR_BASE, asel1_ff}) begin
								state_ff <= L_ACK_A;
								rw_ff <= byte_in[0];
								if (byte_in[0]) req_ff <= ~req_ff;
							end else begin
								state_ff <= L_IDLE;
							end
						end else if (state_ff == L_PTR) begin
							ptr_ff <= byte_in;
							state_ff <= L_ACK_P;
						end else begin
							if (nbyt_ff == 2'h0) data_ff[15:8] <= byte_in;
							if (nbyt_ff == 2'h1) data_ff[7:0] <= byte_in;
							if (nbyt_ff != 2'h3) nbyt_ff <= nbyt_ff + 2'h1;
							state_ff <= L_ACK_W;
						end
					end
				end
				L_RDAT: begin
					cnt_ff <= cnt_ff + 3'h1;
					if (cnt_ff == 3'h7) state_ff <= L_ACK_R;
				end
				L_ACK_R: state_ff <= sda_ff[1] ? L_IDLE : L_RNEXT;
				L_IDLE, L_ACK_A, L_ACK_P, L_ACK_W, L_RNEXT: ;
			endcase
		end else if (fall) begin
			unique case (state_ff)
				L_ACK_A, L_ACK_P, L_ACK_W: begin
					cnt_ff <= 3'h0;
					if (!oe_ff) begin
						oe_ff <= 1'b1;
					end else if (state_ff == L_ACK_A && rw_ff) begin
						sh_ff <= rd_word[15:8];
						oe_ff <= ~rd_word[15];
						lo_ff <= 1'b1;
						state_ff <= L_RDAT;
					end else begin
						oe_ff <= 1'b0;
						state_ff <= (state_ff == L_ACK_A) ? L_PTR : L_WDAT;
					end
				end
				L_RDAT: begin
					sh_ff <= {sh_ff[6:0], 1'b0};
					oe_ff <= ~sh_ff[6];
				end
				L_ACK_R: oe_ff <= 1'b0;
				L_RNEXT: begin
					sh_ff <= lo_ff ? rd_word[7:0] : rd_word[15:8];
					oe_ff <= lo_ff ? ~rd_word[7] : ~rd_word[15];
					lo_ff <= ~lo_ff;
					cnt_ff <= 3'h0;
					state_ff <= L_RDAT;
				end
				L_IDLE, L_ADDR, L_PTR, L_WDAT: ;
			endcase
		end
	end

	assign sda_oe = oe_ff;
	assign busy = busy_ff;
	assign rd_req_tgl = req_ff;
	assign wr_tgl = wr_ff;
	assign xfer = '{ptr: ptr_ff, data: data_ff};

endmodule : tsa_link

// >>> tsa_pkg.sv
package tsa_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int TIMEOUT_MIN_MS = 25;
	localparam int TIMEOUT_MAX_MS = 35;
	localparam int TIMEOUT_CYC = CLK_PER_MS * TIMEOUT_MIN_MS;
	localparam int CONV_PERIOD_MS = 100;
	localparam int CONV_CYC = CLK_PER_MS * CONV_PERIOD_MS;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [7:0] REG_CAP = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_HIGH = 8'h02;
	localparam logic [7:0] REG_LOW = 8'h03;
	localparam logic [7:0] REG_CRIT = 8'h04;
	localparam logic [7:0] REG_TEMP = 8'h05;
	localparam logic [7:0] REG_MFR = 8'h06;
	localparam logic [7:0] REG_DEV = 8'h07;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [15:0] REG_RST = 16'h0000;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int CFG_MODE = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_CRIT_ONLY = 2;
	localparam int CFG_EN = 3;
	localparam int CFG_STAT = 4;
	localparam int CFG_CLR = 5;
	localparam int CFG_SHDN = 8;
	localparam logic [15:0] CFG_WMASK = 16'h07CF;
	localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
	localparam int TEMP_W = 13;
	localparam logic [3:0] ADDR_BASE = 4'h3;

	typedef struct packed {
		logic [7:0] ptr;
		logic [15:0] data;
	} tsa_xfer_t;

endpackage : tsa_pkg

// >>> tsa_top.sv
`timescale 1ns/100ps
module tsa_top #(
	parameter int CONV_CYCLES = tsa_pkg::CONV_CYC,
	parameter int TIMEOUT_CYCLES = tsa_pkg::TIMEOUT_CYC,
	parameter logic [15:0] CAP_VALUE = 16'h0001,
	// Identification values are arbitrary
	parameter logic [15:0] MFR_ID = 16'h5A5A,
	parameter logic [15:0] DEV_ID = 16'h0100,
	parameter logic [3:0] ADDR_BASE = tsa_pkg::ADDR_BASE
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic addr_select_0,
	input wire logic addr_select_1,
	input wire logic addr_select_2,
	output logic event_o,
	output logic event_oe,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [12:0] conv_value
);
	localparam int TMO_LAST = TIMEOUT_CYCLES - 1;

	logic [1:0] rst_ff;
	logic rst_n;
	logic [2:0] scl_ff;
	logic [1:0] busy_ff;
	logic [2:0] wr_s_ff;
	logic [2:0] rd_s_ff;
	logic link_busy;
	logic link_wr_tgl;
	logic link_rd_tgl;
	tsa_pkg::tsa_xfer_t xfer;
	logic scl_s;
	logic busy_s;
	logic scl_fall;
	logic wr_ev;
	logic rd_ev;
	logic clr_ev;
	logic [15:0] cfg_ff;
	logic [15:0] high_ff;
	logic [15:0] low_ff;
	logic [15:0] crit_ff;
	logic [12:0] temp_ff;
	logic temp_valid_ff;
	logic [15:0] rd_word_ff;
	logic [31:0] conv_cnt_ff;
	logic conv_start_ff;
	logic [31:0] tmo_cnt_ff;
	logic abort_tgl_ff;
	logic shdn;
	logic crit_f;
	logic high_f;
	logic low_f;
	logic cond_f;
	logic cond_prev_ff;
	logic evt_int_ff;
	logic nxt_evt_int;
	logic nxt_evt;
	logic evt_ff;
	logic event_oe_ff;
	logic [15:0] stat_word;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rst_ff <= 2'h0;
		else rst_ff <= {rst_ff[0], 1'b1};
	end
	assign rst_n = rst_ff[1];

	// ----------------------------------------
	// Link side
	// ----------------------------------------
	tsa_link #(
		.ADDR_BASE(ADDR_BASE)
	) u_link (
		.link_clk(link_clk),
		.resetn(resetn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.addr_sel_i({addr_select_2, addr_select_1, addr_select_0}),
		.abort_tgl(abort_tgl_ff),
		.rd_word(rd_word_ff),
		.sda_oe(sda_oe),
		.busy(link_busy),
		.rd_req_tgl(link_rd_tgl),
		.wr_tgl(link_wr_tgl),
		.xfer(xfer)
	);
	assign sda_o = 1'b0;

	// ----------------------------------------
	// Crossings into the system clock
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_ff <= 3'h7;
			busy_ff <= 2'h0;
			wr_s_ff <= 3'h0;
			rd_s_ff <= 3'h0;
		end else begin
			scl_ff <= {scl_ff[1:0], scl_i};
			busy_ff <= {busy_ff[0], link_busy};
			wr_s_ff <= {wr_s_ff[1:0], link_wr_tgl};
			rd_s_ff <= {rd_s_ff[1:0], link_rd_tgl};
		end
	end
	assign scl_s = scl_ff[1];
	assign busy_s = busy_ff[1];
	assign scl_fall = scl_ff[2] & ~scl_ff[1];
	assign wr_ev = wr_s_ff[1] ^ wr_s_ff[2];
	assign rd_ev = rd_s_ff[1] ^ rd_s_ff[2];
	assign clr_ev = wr_ev && xfer.ptr == tsa_pkg::REG_CFG && xfer.data[tsa_pkg::CFG_CLR];

	// ----------------------------------------
	// Clock-low timeout
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_cnt_ff <= 32'h0;
			abort_tgl_ff <= 1'b0;
		end else if (!busy_s || scl_s || scl_fall) begin
			tmo_cnt_ff <= 32'h0;
		end else if (tmo_cnt_ff < 32'(TIMEOUT_CYCLES)) begin
			tmo_cnt_ff <= tmo_cnt_ff + 32'h1;
			if (tmo_cnt_ff == 32'(TMO_LAST)) abort_tgl_ff <= ~abort_tgl_ff;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= tsa_pkg::REG_RST;
			high_ff <= tsa_pkg::REG_RST;
			low_ff <= tsa_pkg::REG_RST;
			crit_ff <= tsa_pkg::REG_RST;
		end else if (wr_ev) begin
			unique case (xfer.ptr)
				tsa_pkg::REG_CFG: cfg_ff <= xfer.data & tsa_pkg::CFG_WMASK;
				tsa_pkg::REG_HIGH: high_ff <= xfer.data & tsa_pkg::LIMIT_MASK;
				tsa_pkg::REG_LOW: low_ff <= xfer.data & tsa_pkg::LIMIT_MASK;
				tsa_pkg::REG_CRIT: crit_ff <= xfer.data & tsa_pkg::LIMIT_MASK;
				default: ;
			endcase
		end
	end
	assign shdn = cfg_ff[tsa_pkg::CFG_SHDN];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_word_ff <= tsa_pkg::REG_RST;
		end else if (rd_ev) begin
			unique case (xfer.ptr)
				tsa_pkg::REG_CAP: rd_word_ff <= CAP_VALUE;
				tsa_pkg::REG_CFG: begin
					rd_word_ff <= cfg_ff;
					rd_word_ff[tsa_pkg::CFG_STAT] <= evt_ff;
				end
				tsa_pkg::REG_HIGH: rd_word_ff <= high_ff;
				tsa_pkg::REG_LOW: rd_word_ff <= low_ff;
				tsa_pkg::REG_CRIT: rd_word_ff <= crit_ff;
				tsa_pkg::REG_TEMP: rd_word_ff <= stat_word;
				tsa_pkg::REG_MFR: rd_word_ff <= MFR_ID;
				tsa_pkg::REG_DEV: rd_word_ff <= DEV_ID;
				default: rd_word_ff <= tsa_pkg::REG_RST;
			endcase
		end
	end

	// ----------------------------------------
	// Conversion
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_ff <= 32'h0;
			conv_start_ff <= 1'b0;
		end else begin
			conv_start_ff <= !shdn && conv_cnt_ff == 32'h0;
			if (shdn || conv_cnt_ff == 32'(CONV_CYCLES - 1)) conv_cnt_ff <= 32'h0;
			else conv_cnt_ff <= conv_cnt_ff + 32'h1;
		end
	end
	assign conv_start = conv_start_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_ff <= 13'h0000;
			temp_valid_ff <= 1'b0;
		end else if (conv_done && !shdn) begin
			temp_ff <= conv_value;
			temp_valid_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Limit compare
	// ----------------------------------------
	assign crit_f = temp_valid_ff && $signed(temp_ff) >= $signed(crit_ff[12:0]);
	assign high_f = temp_valid_ff && $signed(temp_ff) > $signed(high_ff[12:0]);
	assign low_f = temp_valid_ff && $signed(temp_ff) < $signed(low_ff[12:0]);
	assign stat_word = {crit_f, high_f, low_f, temp_ff};
	assign cond_f = high_f | low_f;

	// ----------------------------------------
	// Alert state
	// ----------------------------------------
	always_comb begin
		nxt_evt_int = evt_int_ff;
		if (clr_ev) nxt_evt_int = 1'b0;
		if (cond_f != cond_prev_ff) nxt_evt_int = 1'b1;
		if (cfg_ff[tsa_pkg::CFG_CRIT_ONLY]) nxt_evt = crit_f;
		else if (cfg_ff[tsa_pkg::CFG_MODE]) nxt_evt = nxt_evt_int | crit_f;
		else nxt_evt = cond_f | crit_f;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev_ff <= 1'b0;
			evt_int_ff <= 1'b0;
			evt_ff <= 1'b0;
		end else if (!shdn) begin
			cond_prev_ff <= cond_f;
			evt_int_ff <= nxt_evt_int;
			evt_ff <= nxt_evt;
		end
	end

	// Pin pulled low only while enabled: when asserted and active low, or idle and active high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) event_oe_ff <= 1'b0;
		else event_oe_ff <= cfg_ff[tsa_pkg::CFG_EN] & (evt_ff ^ cfg_ff[tsa_pkg::CFG_POL]);
	end
	assign event_oe = event_oe_ff;
	assign event_o = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_high_wr;
		wr_ev && xfer.ptr == tsa_pkg::REG_HIGH;
	endsequence

	sequence s_scl_stuck;
		busy_s && !scl_s && !scl_fall && tmo_cnt_ff == 32'(TMO_LAST);
	endsequence

	chk_timeout_abort: assert property (s_scl_stuck |=> abort_tgl_ff != $past(abort_tgl_ff))
		else $error("timeout did not abort");
	chk_timeout_restart: assert property (scl_fall |=> tmo_cnt_ff == 32'h0)
		else $error("timeout not restarted on fall");
	chk_limit_write: assert property (s_high_wr
		|=> high_ff == ($past(xfer.data) & tsa_pkg::LIMIT_MASK))
		else $error("high limit write wrong");
	chk_conv_bound: assert property (conv_cnt_ff < 32'(CONV_CYCLES))
		else $error("conversion period exceeded");
	chk_tdr_frozen: assert property ($past(shdn) |-> $stable(temp_ff))
		else $error("result changed in shutdown");
	chk_status_crit: assert property (stat_word[15] == (temp_valid_ff
		&& $signed(stat_word[12:0]) >= $signed(crit_ff[12:0])))
		else $error("critical status bit wrong");
	chk_oe_disabled: assert property (!cfg_ff[tsa_pkg::CFG_EN] |=> !event_oe_ff)
		else $error("alert driven while disabled");
	chk_oe_polarity: assert property (cfg_ff[tsa_pkg::CFG_EN] && evt_ff
		|=> event_oe_ff == !$past(cfg_ff[tsa_pkg::CFG_POL]))
		else $error("alert polarity wrong");
	chk_crit_hold: assert property (!shdn && crit_f |=> evt_ff)
		else $error("critical alert not asserted");
	chk_clear_event: assert property (clr_ev && !shdn && cfg_ff[tsa_pkg::CFG_MODE]
		&& !cfg_ff[tsa_pkg::CFG_CRIT_ONLY] && !crit_f && cond_f == cond_prev_ff
		|=> !evt_ff)
		else $error("clear did not release alert");
	chk_valid_gate: assert property (!temp_valid_ff |-> !evt_ff)
		else $error("alert before first result");

endmodule : tsa_top

// >>> tsa_top_tb.sv
`timescale 1ns/100ps
module tsa_top_tb;
	localparam int CONV = 200;
	// Arbitrary maker code, overridden so the bench knows it
	localparam logic [15:0] MFR = 16'hA55A;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic resetn = 1'b0;
	logic scl;
	logic host_oe;
	logic sda_oe;
	logic sda;
	logic sda_o;
	logic event_o;
	logic evt_pin;
	logic [2:0] asel = 3'h0;
	logic event_oe;
	logic conv_start;
	logic conv_done = 1'b0;
	logic [12:0] conv_value = 13'h0000;
	logic [12:0] temp_val = 13'h0100;
	logic [15:0] hi = 16'h0000;
	logic [15:0] lo = 16'h0000;
	logic [15:0] cr = 16'h0000;
	logic [15:0] w;
	logic [15:0] rd;
	logic ack;
	logic shut = 1'b0;
	int gap = 0;
	int seed = 46;
	int bad_count = 0;
	int comparisons = 0;

	always #20 clk = ~clk;
	initial #3 forever #7.5 link_clk = ~link_clk;
	// Wired-and bus with pull-ups; device drives sda_o only while enabled
	assign sda = ~host_oe & (~sda_oe | sda_o);
	assign evt_pin = ~event_oe | event_o;

	tsa_top #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(100), .MFR_ID(MFR)) dut_u (
		.clk(clk), .resetn(resetn), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .addr_select_0(asel[0]), .addr_select_1(asel[1]),
		.addr_select_2(asel[2]), .event_o(event_o), .event_oe(event_oe),
		.conv_start(conv_start), .conv_done(conv_done), .conv_value(conv_value));
	tsa_host host_u (.clk(clk), .sda_i(sda), .scl(scl), .sda_oe(host_oe));

	// ----------------------------------------
	// Sensor unit and conversion spacing
	// ----------------------------------------
	always @(posedge clk) begin
		conv_done <= conv_start;
		conv_value <= temp_val;
		if (conv_start === 1'b1) begin
			chk1(shut, 1'b0);
			chk1(gap < CONV, 1'b1);
			gap <= 0;
		end else begin
			gap <= shut ? 0 : gap + 1;
		end
	end

	// ----------------------------------------
	// Checks and bus cycles
	// ----------------------------------------
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk16
	function automatic logic [7:0] adr(input logic rw);
		adr = {tsa_pkg::ADDR_BASE, asel, rw};
	endfunction : adr
	function automatic logic [15:0] exp_temp(input logic [12:0] t);
		exp_temp = {$signed(t) >= $signed(cr[12:0]), $signed(t) > $signed(hi[12:0]),
			$signed(t) < $signed(lo[12:0]), t};
	endfunction : exp_temp
	task automatic wreg(input logic [7:0] p, input logic [15:0] d, input logic fin);
		logic a0;
		logic a1;
		logic a2;
		logic a3;
		host_u.start();
		host_u.put(adr(1'b0), a0);
		host_u.put(p, a1);
		host_u.put(d[15:8], a2);
		host_u.put(d[7:0], a3);
		if (fin) host_u.stop();
		chk1(a0 & a1 & a2 & a3, 1'b1);
		host_u.hold(20);
	endtask : wreg
	task automatic rreg(input logic [7:0] p, input logic sel, input logic [15:0] exp);
		logic a0;
		logic a1;
		if (sel) begin
			host_u.start();
			host_u.put(adr(1'b0), a0);
			host_u.put(p, a1);
			chk1(a0 & a1, 1'b1);
		end
		host_u.start();
		host_u.put(adr(1'b1), a0);
		host_u.get(1'b0, rd[15:8]);
		host_u.get(1'b1, rd[7:0]);
		host_u.stop();
		chk1(a0, 1'b1);
		chk16(rd, exp);
	endtask : rreg
	task automatic alert(input logic [7:0] p, input logic [15:0] d, input logic exp);
		wreg(p, d, 1'b1);
		chk1(evt_pin, ~exp);
	endtask : alert
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		// About 95k cycles of bus traffic expected
		repeat (98000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		@(posedge clk);
		asel <= 3'($random(seed));
		repeat (9) @(posedge clk);
		resetn <= 1'b1;
		repeat (10) @(posedge clk);
		chk1(event_oe, 1'b0);
		rreg(8'h00, 1'b0, 16'h0001);
		// Alert state bit set: result already above the zero limits
		for (int i = 1; i < 5; i++) begin
			rreg(8'(i), 1'b1, 16'(i == 1) << tsa_pkg::CFG_STAT);
		end
		rreg(tsa_pkg::REG_MFR, 1'b1, MFR);
		host_u.start();
		host_u.put({tsa_pkg::ADDR_BASE, ~asel, 1'b1}, ack);
		host_u.stop();
		chk1(ack, 1'b0);
		wreg(tsa_pkg::REG_HIGH, 16'h0AAC, 1'b0);
		rreg(8'h00, 1'b0, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			hi = 16'($random(seed)) & tsa_pkg::LIMIT_MASK;
			w = 16'($random(seed));
			lo = w & tsa_pkg::LIMIT_MASK;
			cr = (k == 0) ? hi : 16'($random(seed)) & tsa_pkg::LIMIT_MASK;
			temp_val <= (k == 0) ? hi[12:0] : 13'($random(seed));
			wreg(tsa_pkg::REG_HIGH, hi, 1'b1);
			wreg(tsa_pkg::REG_LOW, w, 1'b1);
			wreg(tsa_pkg::REG_CRIT, cr, 1'b1);
			rreg(tsa_pkg::REG_LOW, 1'b1, lo);
			repeat (2 * CONV) @(posedge clk);
			rreg(tsa_pkg::REG_TEMP, 1'b1, exp_temp(temp_val));
		end
		hi = 16'h0190;
		lo = 16'h1E70;
		cr = 16'h0320;
		temp_val <= 13'h0100;
		wreg(tsa_pkg::REG_HIGH, hi, 1'b1);
		wreg(tsa_pkg::REG_LOW, lo, 1'b1);
		wreg(tsa_pkg::REG_CRIT, cr, 1'b1);
		repeat (2 * CONV) @(posedge clk);
		alert(tsa_pkg::REG_CFG, 16'h0008, 1'b0);
		alert(tsa_pkg::REG_HIGH, 16'h00F0, 1'b1);
		alert(tsa_pkg::REG_CFG, 16'h000A, 1'b0);
		alert(tsa_pkg::REG_CFG, 16'h000C, 1'b0);
		alert(tsa_pkg::REG_CRIT, 16'h00C0, 1'b1);
		alert(tsa_pkg::REG_CFG, 16'h0029, 1'b1);
		wreg(tsa_pkg::REG_CRIT, cr, 1'b1);
		alert(tsa_pkg::REG_CFG, 16'h0029, 1'b0);
		alert(tsa_pkg::REG_HIGH, hi, 1'b1);
		alert(tsa_pkg::REG_CFG, 16'h0029, 1'b0);
		alert(tsa_pkg::REG_CFG, 16'h0100, 1'b0);
		shut <= 1'b1;
		temp_val <= 13'h1C90;
		repeat (3 * CONV) @(posedge clk);
		rreg(tsa_pkg::REG_TEMP, 1'b1, 16'h0100);
		wreg(tsa_pkg::REG_CFG, 16'h0000, 1'b0);
		shut <= 1'b0;
		host_u.stop();
		host_u.start();
		host_u.put(adr(1'b0), ack);
		host_u.put(tsa_pkg::REG_CAP, ack);
		host_u.stop();
		rreg(8'h00, 1'b0, 16'h0001);
		host_u.start();
		host_u.put(adr(1'b1), ack);
		host_u.hold(60);
		chk1(sda_oe, 1'b1);
		host_u.hold(90);
		chk1(sda_oe, 1'b0);
		host_u.stop();
		rreg(8'h00, 1'b0, 16'h0001);
		chk1(sda_o | event_o, 1'b0);
		tally_and_finish();
	end
endmodule : tsa_top_tb
